//--- aofp_capture_model.sv
/* capture logic on the far side of the parallel bus.
   assumes it shares the design clock; released lines read as noise. */
`timescale 1ns/1ns
module aofp_capture_model #(
  parameter int DISCARD = 100
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // parallel bus
  input wire logic [13:0] sampleWord,
  input wire logic [13:0] sampleWordOe,
  input wire logic overrangeFlag,
  input wire logic overrangeFlagOe,
  // captured result
  output logic [14:0] capWord,
  output logic ready
);
  logic [14:0] busLevel;
  logic [7:0] hold_q;
  // a floating line shows the inverse of its last level, not a held value
  always_comb begin
    for (int i = 0; i < 14; i++) busLevel[i] = sampleWordOe[i] ? sampleWord[i] : ~capWord[i];
    busLevel[14] = overrangeFlagOe ? overrangeFlag : ~capWord[14];
  end
  // one wait serves nap, sleep and clock restarts; sleep would want far longer
  always_ff @(posedge clock) begin
    capWord <= busLevel;
    if (reset || !overrangeFlagOe) hold_q <= 8'(DISCARD);
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
  end
  assign ready = hold_q == 8'h00;
endmodule

//--- aofp_delay.sv
/*
  fixed-latency delay line for the sample word and the overrange bit.
  assumes one clock; contents are not cleared by reset, only the valid tags.
*/
`timescale 1ns/1ns
module aofp_delay (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // write side
  input wire logic [aofp_pkg::SAMPLE_W:0] inWord,
  input wire logic inValid,
  // read side, registered
  output logic [aofp_pkg::SAMPLE_W:0] outWord,
  output logic outValid
);

  typedef struct packed {
    logic [aofp_pkg::LATENCY-1:0][aofp_pkg::SAMPLE_W:0] word;
    logic [aofp_pkg::LATENCY-1:0] valid;
  } aofp_dly_s;

  aofp_dly_s state_q;
  aofp_dly_s state_d;

  always_comb begin
    state_d = state_q;
    state_d.word = {state_q.word[aofp_pkg::LATENCY-2:0], inWord};
    state_d.valid = {state_q.valid[aofp_pkg::LATENCY-2:0], inValid};
    if (reset) begin
      state_d.valid = '0;
    end
  end

  always_ff @(posedge clock) begin
    state_q <= state_d;
  end

  assign outWord = state_q.word[aofp_pkg::LATENCY-1];
  assign outValid = state_q.valid[aofp_pkg::LATENCY-1];

endmodule

//--- aofp_pkg.sv
/*
  package for the converter output formatter: wishbone register map,
  field positions, reset values and the state enumeration.
  assumes a 32-bit classic wishbone slave on a 250 MHz clock.
*/
package aofp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 14;
  localparam int LATENCY = 5;
  localparam int LAT_W = 3;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_SAMPLE = 8'h10;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_OE_N = 2;
  localparam int CTRL_SHUTDOWN_SELECT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

  // ----------------------------------------------------------------
  // interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_OVR = 0;
  localparam int IRQ_MODE = 1;
  localparam int IRQ_W = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [SAMPLE_W-1:0] CODE_MAX = 14'h3fff;
  localparam logic [SAMPLE_W-1:0] CODE_MIN = 14'h0000;
  localparam logic [SAMPLE_W-1:0] CODE_MID = 14'h2000;

  // format pin levels: 0 gnd, 1 third, 2 two thirds, 3 supply
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
  localparam logic [1:0] LVL_SUPPLY = 2'h3;

  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_NAP = 2'b01,
    PWR_SLEEP = 2'b10
  } aofp_pwr_e;

endpackage

//--- aofp_top.sv
/*
  output formatter and power mode control of a 14-bit sampling converter.
  raw quantiser results arrive each clock with above/below range flags;
  the formatter codes, delays and drives them onto the three-state bus.
  assumes a classic wishbone master and pins from the same clock domain
  except the format level and the two strap inputs, which are synchronised.
*/
// Summary of operation
// - offset binary: midscale top bit, ends saturate
// - twos complement: offset binary with msb inverted
// - overrange flag high beyond range, word saturates
// - format levels gnd and third: offset binary
// - format levels two thirds and supply: twos complement
// - stabiliser on only for intermediate levels
// - enable high floats data and overrange
// - shutdown low gives normal conversion
// - shutdown and enable high give sleep
// - shutdown high, enable low gives nap
// - sleep and nap float data and overrange
// - stabiliser samples on rising edge only
`timescale 1ns/1ns
module aofp_top (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // converter core
  input wire logic [aofp_pkg::SAMPLE_W-1:0] rawCode,
  input wire logic rawAbove,
  input wire logic rawBelow,
  input wire logic rawStrobe,
  // pins, asynchronous
  input wire logic [1:0] formatLevel,
  input wire logic outputEnablePin_n,
  input wire logic shutdownSelectPin,
  // parallel bus, three-state split
  output logic [aofp_pkg::SAMPLE_W-1:0] sampleWord,
  output logic [aofp_pkg::SAMPLE_W-1:0] sampleWordOe,
  output logic overrangeFlag,
  output logic overrangeFlagOe,
  // analog side controls
  output logic dutyStabilizerOn,
  output logic referencePowered,
  output logic coreActive,
  output logic risingOnlySampling,
  // interrupt
  output logic irq
);

  typedef struct packed {
    logic [2:0][1:0] lvlSync;
    logic [2:0] oeSync;
    logic [2:0] shdnSync;
    logic [1:0] lvl;
    logic oePinN;
    logic shdnPin;
    logic [31:0] ctrl;
    logic [aofp_pkg::IRQ_W-1:0] irqStat;
    logic [aofp_pkg::IRQ_W-1:0] irqMask;
    logic ack;
    logic [31:0] rdata;
    logic [aofp_pkg::SAMPLE_W-1:0] word;
    logic ovr;
    logic busOn;
    aofp_pkg::aofp_pwr_e pwr;
    logic [aofp_pkg::SAMPLE_W:0] lastSample;
  } aofp_top_s;

  aofp_top_s state_q;
  aofp_top_s state_d;

  logic [aofp_pkg::SAMPLE_W:0] dlyIn;
  logic dlyInValid;
  logic [aofp_pkg::SAMPLE_W:0] dlyOut;
  logic dlyOutValid;
  logic twosComp;
  logic oeN;
  logic shutdown_select;
  logic [1:0] lvlEff;
  logic wbReq;
  logic wbWrite;

  // ----------------------------------------------------------------
  // coding functions
  // ----------------------------------------------------------------
  function automatic logic [aofp_pkg::SAMPLE_W:0] codeSample(
    input logic [aofp_pkg::SAMPLE_W-1:0] code,
    input logic above,
    input logic below,
    input logic twos
  );
    logic [aofp_pkg::SAMPLE_W-1:0] ob;
    ob = code;
    if (above) begin
      ob = aofp_pkg::CODE_MAX;
    end else if (below) begin
      ob = aofp_pkg::CODE_MIN;
    end
    if (twos) begin
      ob[aofp_pkg::SAMPLE_W-1] = ~ob[aofp_pkg::SAMPLE_W-1];
    end
    return {above | below, ob};
  endfunction

  function automatic logic isTwos(input logic [1:0] lvl);
    return (lvl == aofp_pkg::LVL_TWO_THIRD) || (lvl == aofp_pkg::LVL_SUPPLY);
  endfunction

  function automatic logic isStab(input logic [1:0] lvl);
    return (lvl == aofp_pkg::LVL_THIRD) || (lvl == aofp_pkg::LVL_TWO_THIRD);
  endfunction

  function automatic aofp_pkg::aofp_pwr_e pwrDecode(
    input logic shdnIn,
    input logic oeNIn
  );
    aofp_pkg::aofp_pwr_e mode;
    case ({shdnIn, oeNIn})
      2'b10: begin
        mode = aofp_pkg::PWR_NAP;
      end
      2'b11: begin
        mode = aofp_pkg::PWR_SLEEP;
      end
      default: begin
        mode = aofp_pkg::PWR_NORMAL;
      end
    endcase
    return mode;
  endfunction

  function automatic logic [31:0] statusWord(
    input logic [1:0] lvl,
    input logic shdnIn,
    input logic oeNIn,
    input aofp_pkg::aofp_pwr_e pwr,
    input logic twos,
    input logic stab
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[1:0] = lvl;
    w[2] = shdnIn;
    w[3] = oeNIn;
    w[5:4] = pwr;
    w[6] = twos;
    w[7] = stab;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // effective controls: pins or software override
  // ----------------------------------------------------------------
  // software sees the strap but can force: mode and shutdown ctrl bits OR with the pin, the enable ctrl bit ANDs with it
  always_comb begin
    lvlEff = state_q.lvl | state_q.ctrl[aofp_pkg::CTRL_MODE_LO +: 2];
    oeN = state_q.oePinN & state_q.ctrl[aofp_pkg::CTRL_OE_N];
    shutdown_select = state_q.shdnPin | state_q.ctrl[aofp_pkg::CTRL_SHUTDOWN_SELECT];
    twosComp = isTwos(lvlEff);
    wbReq = wbCyc & wbStb & ~state_q.ack;
    wbWrite = wbCyc & wbStb & wbWe & state_q.ack;
  end

  // ----------------------------------------------------------------
  // pipeline
  // ----------------------------------------------------------------
  // core idle in nap and sleep, so no samples enter the delay line
  assign dlyIn = codeSample(rawCode, rawAbove, rawBelow, twosComp);
  assign dlyInValid = rawStrobe & (state_q.pwr == aofp_pkg::PWR_NORMAL);

  aofp_delay u_delay (
    .clock(clock),
    .reset(reset),
    .inWord(dlyIn),
    .inValid(dlyInValid),
    .outWord(dlyOut),
    .outValid(dlyOutValid)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // ----------------------------------------------------------------
    // three-stage sync, change taken when stages two and three agree
    // ----------------------------------------------------------------
    state_d.lvlSync = {state_q.lvlSync[1:0], formatLevel};
    state_d.oeSync = {state_q.oeSync[1:0], outputEnablePin_n};
    state_d.shdnSync = {state_q.shdnSync[1:0], shutdownSelectPin};
    if (state_q.lvlSync[1] == state_q.lvlSync[2]) begin
      state_d.lvl = state_q.lvlSync[2];
    end
    if (state_q.oeSync[1] == state_q.oeSync[2]) begin
      state_d.oePinN = state_q.oeSync[2];
    end
    if (state_q.shdnSync[1] == state_q.shdnSync[2]) begin
      state_d.shdnPin = state_q.shdnSync[2];
    end

    // ----------------------------------------------------------------
    // power mode decode
    // ----------------------------------------------------------------
    state_d.pwr = pwrDecode(shutdown_select, oeN);
    // float in any low-power mode or while enable is high
    state_d.busOn = ~oeN & ~shutdown_select;

    // one bus update per clock with fixed latency
    if (dlyOutValid) begin
      state_d.word = dlyOut[aofp_pkg::SAMPLE_W-1:0];
      state_d.ovr = dlyOut[aofp_pkg::SAMPLE_W];
      state_d.lastSample = dlyOut;
    end

    // interrupt events; set wins over write-one clear
    if (wbWrite && wbAdr == aofp_pkg::OFS_IRQ && wbSel[0]) begin
      state_d.irqStat = state_q.irqStat & ~wbDatI[aofp_pkg::IRQ_W-1:0];
    end
    if (dlyOutValid && dlyOut[aofp_pkg::SAMPLE_W]) begin
      state_d.irqStat[aofp_pkg::IRQ_OVR] = 1'b1;
    end
    if (state_d.lvl != state_q.lvl) begin
      state_d.irqStat[aofp_pkg::IRQ_MODE] = 1'b1;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // committed on the edge that ends ack, while the master still holds data
    if (wbWrite && wbSel[0]) begin
      if (wbAdr == aofp_pkg::OFS_CTRL) begin
        state_d.ctrl[7:0] = {4'h0, wbDatI[3:0]};
      end else if (wbAdr == aofp_pkg::OFS_MASK) begin
        state_d.irqMask = wbDatI[aofp_pkg::IRQ_W-1:0];
      end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // wishbone: ack one cycle after request, dropped next cycle
    state_d.ack = wbReq;
    state_d.rdata = 32'h0000_0000;
    if (wbReq) begin
      if (wbAdr == aofp_pkg::OFS_CTRL) begin
        state_d.rdata = state_q.ctrl;
      end else if (wbAdr == aofp_pkg::OFS_STATUS) begin
        state_d.rdata = statusWord(state_q.lvl, shutdown_select, oeN, state_q.pwr, twosComp, isStab(lvlEff));
      end else if (wbAdr == aofp_pkg::OFS_IRQ) begin
        state_d.rdata = {30'h0, state_q.irqStat};
      end else if (wbAdr == aofp_pkg::OFS_MASK) begin
        state_d.rdata = {30'h0, state_q.irqMask};
      end else if (wbAdr == aofp_pkg::OFS_SAMPLE) begin
        state_d.rdata = {17'h0, state_q.lastSample};
      end
    end

    if (reset) begin
      state_d.lvl = aofp_pkg::LVL_GND;
      state_d.oePinN = 1'b1;
      state_d.shdnPin = 1'b0;
      state_d.ctrl = aofp_pkg::CTRL_RESET;
      state_d.irqStat = aofp_pkg::IRQ_RESET;
      state_d.irqMask = aofp_pkg::IRQ_RESET;
      state_d.ack = 1'b0;
      state_d.rdata = 32'h0000_0000;
      state_d.word = aofp_pkg::CODE_MID;
      state_d.ovr = 1'b0;
      state_d.busOn = 1'b0;
      state_d.pwr = aofp_pkg::PWR_NORMAL;
      state_d.lastSample = '0;
    end
  end

  always_ff @(posedge clock) begin
    state_q <= state_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sampleWord = state_q.word;
  assign overrangeFlag = state_q.ovr;
  assign sampleWordOe = {aofp_pkg::SAMPLE_W{state_q.busOn}};
  assign overrangeFlagOe = state_q.busOn;
  assign dutyStabilizerOn = isStab(lvlEff);
  // with stabiliser on, the falling edge is made internally
  assign risingOnlySampling = isStab(lvlEff);
  assign referencePowered = state_q.pwr != aofp_pkg::PWR_SLEEP;
  assign coreActive = state_q.pwr == aofp_pkg::PWR_NORMAL;
  assign wbAck = state_q.ack;
  assign wbDatO = state_q.rdata;
  assign irq = |(state_q.irqStat & state_q.irqMask);

endmodule

//--- aofp_top_monitor.sv
/* pin and stream checker for the output formatter.
   assumes the control register stays at reset, so the pins alone decide. */
`timescale 1ns/1ns
module aofp_top_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // core and pins
  input wire logic [13:0] rawCode,
  input wire logic rawAbove,
  input wire logic rawBelow,
  input wire logic rawStrobe,
  input wire logic [1:0] formatLevel,
  input wire logic outputEnablePin_n,
  input wire logic shutdownSelectPin,
  // outputs
  input wire logic [13:0] sampleWord,
  input wire logic [13:0] sampleWordOe,
  input wire logic overrangeFlag,
  input wire logic overrangeFlagOe,
  input wire logic dutyStabilizerOn,
  input wire logic referencePowered,
  input wire logic coreActive,
  input wire logic risingOnlySampling
);
  // ----
  // calm counter: running and format unchanged
  // ----
  logic [1:0] lastLvl_q;
  logic [3:0] calm_q;
  always_ff @(posedge clock) begin
    lastLvl_q <= formatLevel;
    if (reset || shutdownSelectPin || formatLevel != lastLvl_q) calm_q <= 4'h0;
    else if (calm_q != 4'hf) calm_q <= calm_q + 4'h1;
  end
  function automatic logic [13:0] expWord(logic [13:0] c, logic a, logic b, logic t);
    return (a ? 14'h3fff : b ? 14'h0000 : c) ^ {t, 13'h0000};
  endfunction
  // ----
  // assertions
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_data_coding: assert property (
    calm_q > 4'h7 && rawStrobe && !(rawAbove && rawBelow) |-> ##6 (calm_q < 4'h8 ||
    sampleWord == expWord($past(rawCode, 6), $past(rawAbove, 6), $past(rawBelow, 6), formatLevel[1])))
    else $error("sample word coding wrong");
  a_ovr_flag: assert property (
    calm_q > 4'h7 && rawStrobe |-> ##6 (calm_q < 4'h8 || overrangeFlag == ($past(rawAbove, 6) || $past(rawBelow, 6))))
    else $error("overrange flag wrong");
  a_oe_float: assert property (
    outputEnablePin_n [*6] |-> sampleWordOe == 14'h0000 && !overrangeFlagOe) else $error("bus not floated");
  a_oe_drive: assert property (
    (!shutdownSelectPin && !outputEnablePin_n) [*6] |-> &sampleWordOe && overrangeFlagOe) else $error("bus not driven");
  a_mode_float: assert property (
    shutdownSelectPin [*6] |-> sampleWordOe == 14'h0000 && !overrangeFlagOe) else $error("bus driven in low power");
  a_sleep_off: assert property (
    (shutdownSelectPin && outputEnablePin_n) [*6] |-> !referencePowered && !coreActive) else $error("sleep wrong");
  a_nap_ref: assert property (
    (shutdownSelectPin && !outputEnablePin_n) [*6] |-> referencePowered && !coreActive) else $error("nap wrong");
  a_normal_run: assert property (
    !shutdownSelectPin [*6] |-> coreActive && referencePowered) else $error("normal mode wrong");
  a_stab_level: assert property (
    $stable(formatLevel) [*5] |-> dutyStabilizerOn == (formatLevel == 2'h1 || formatLevel == 2'h2))
    else $error("stabilizer wrong");
  a_rise_only: assert property (
    $stable(formatLevel) [*5] |-> risingOnlySampling == (formatLevel == 2'h1 || formatLevel == 2'h2))
    else $error("edge select wrong");
  c_over: cover property (rawStrobe && rawAbove && calm_q > 4'h7);
  c_nap: cover property (shutdownSelectPin && !outputEnablePin_n && !coreActive);
  c_sleep: cover property (!referencePowered);
endmodule
bind aofp_top aofp_top_monitor mon (.clock(clock), .reset(reset), .rawCode(rawCode), .rawAbove(rawAbove),
  .rawBelow(rawBelow), .rawStrobe(rawStrobe), .formatLevel(formatLevel), .outputEnablePin_n(outputEnablePin_n),
  .shutdownSelectPin(shutdownSelectPin), .sampleWord(sampleWord), .sampleWordOe(sampleWordOe),
  .overrangeFlag(overrangeFlag), .overrangeFlagOe(overrangeFlagOe), .dutyStabilizerOn(dutyStabilizerOn),
  .referencePowered(referencePowered), .coreActive(coreActive), .risingOnlySampling(risingOnlySampling));

//--- tb.sv
/* self-checking bench for the output formatter.
   assumes the control register stays at reset, so the pins alone decide. */
`timescale 1ns/1ns
module tb;
  typedef struct {int due; logic [14:0] exp;} aofp_note_s;
  logic clock = 1'h0, reset = 1'h1, wbCyc = 1'h0, wbStb = 1'h0, wbWe = 1'h0, wbAck, irq, ready;
  logic rawAbove = 1'h0, rawBelow = 1'h0, rawStrobe = 1'h0, outputEnablePin_n = 1'h0, shutdownSelectPin = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  logic [13:0] rawCode = 14'h0, sampleWord, sampleWordOe;
  logic [1:0] formatLevel = 2'h0;
  logic [14:0] capWord;
  logic overrangeFlag, overrangeFlagOe, dutyStabilizerOn, referencePowered, coreActive, risingOnlySampling;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  aofp_note_s notes[$];
  aofp_top uut (.clock(clock), .reset(reset), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(4'hf), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .rawCode(rawCode), .rawAbove(rawAbove),
    .rawBelow(rawBelow), .rawStrobe(rawStrobe), .formatLevel(formatLevel), .outputEnablePin_n(outputEnablePin_n),
    .shutdownSelectPin(shutdownSelectPin), .sampleWord(sampleWord), .sampleWordOe(sampleWordOe),
    .overrangeFlag(overrangeFlag), .overrangeFlagOe(overrangeFlagOe), .dutyStabilizerOn(dutyStabilizerOn),
    .referencePowered(referencePowered), .coreActive(coreActive), .risingOnlySampling(risingOnlySampling), .irq(irq));
  aofp_capture_model partner (.clock(clock), .reset(reset), .sampleWord(sampleWord), .sampleWordOe(sampleWordOe),
    .overrangeFlag(overrangeFlag), .overrangeFlagOe(overrangeFlagOe), .capWord(capWord), .ready(ready));
  // ----
  // tasks
  // ----
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (notes.size() != 0) begin
      error_cnt++;
      $display("MISMATCH pending notes expected 0 seen %0d", notes.size());
    end
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wbXfer(logic we, logic [7:0] adr, logic [31:0] dat);
    @(posedge clock);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    do @(posedge clock); while (wbAck !== 1'h1);
    rd = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask
  // expected pin word: flag on top, saturate, msb flipped for twos
  task automatic sample(logic [13:0] c, logic a, logic b);
    @(posedge clock);
    rawCode <= c;
    rawAbove <= a;
    rawBelow <= b;
    rawStrobe <= 1'h1;
    notes.push_back('{cyc + 8, {a | b, (a ? 14'h3fff : b ? 14'h0000 : c) ^ {formatLevel[1], 13'h0000}}});
  endtask
  task automatic stream(int n);
    for (int i = 0; i < n; i++) sample(i > 3 ? {14{i[0]}} : 14'($urandom), i == 2, i == 3);
    @(posedge clock);
    rawStrobe <= 1'h0;
    repeat (12) @(posedge clock);
  endtask
  // ----
  // clock, watcher and sequence
  // ----
  initial forever #2 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  initial forever begin
    @(posedge clock);
    #1;
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      check("captured word", notes[0].exp, capWord);
      void'(notes.pop_front());
    end
    if (cyc > 2000) begin
      error_cnt++;
      $display("MISMATCH timeout expected %0d seen %0d", 2000, cyc);
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(40));
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    wbXfer(1'h0, aofp_pkg::OFS_CTRL, 32'h0);
    check("ctrl", aofp_pkg::CTRL_RESET, rd);
    wbXfer(1'h0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rd);
    wbXfer(1'h1, aofp_pkg::OFS_MASK, 32'h1);
    wbXfer(1'h0, aofp_pkg::OFS_MASK, 32'h0);
    check("mask", 32'h1, rd);
    $display("test registers done");
    for (int l = 0; l < 4; l++) begin
      formatLevel <= 2'(l);
      repeat (10) @(posedge clock);
      check("stabilizer", l == 1 || l == 2, dutyStabilizerOn);
      check("rising only", l == 1 || l == 2, risingOnlySampling);
      stream(6);
    end
    wbXfer(1'h0, aofp_pkg::OFS_SAMPLE, 32'h0);
    check("last sample", 32'h0000_1fff, rd);
    wbXfer(1'h0, aofp_pkg::OFS_STATUS, 32'h0);
    check("status", 32'h0000_0043, rd);
    $display("test coding done");
    check("irq", 1'h1, irq);
    wbXfer(1'h0, aofp_pkg::OFS_IRQ, 32'h0);
    check("irq bits", 32'h3, rd);
    wbXfer(1'h1, aofp_pkg::OFS_IRQ, 32'h3);
    wbXfer(1'h1, aofp_pkg::OFS_MASK, 32'h0);
    check("irq cleared", 1'h0, irq);
    stream(4);
    check("irq masked", 1'h0, irq);
    $display("test interrupt done");
    for (int m = 0; m < 4; m++) begin
      shutdownSelectPin <= m[1];
      outputEnablePin_n <= m[0];
      repeat (8) @(posedge clock);
      check("reference", m != 3, referencePowered);
      check("core", m < 2, coreActive);
      check("enables", {15{m == 0}}, {overrangeFlagOe, sampleWordOe});
    end
    shutdownSelectPin <= 1'h0;
    outputEnablePin_n <= 1'h0;
    @(posedge clock);
    while (ready !== 1'h1) @(posedge clock);
    stream(6);
    $display("test power modes done");
    report_and_stop();
  end
endmodule
